// file: rtl/dif_ctrl.sv
// Notes on behaviour
// - with the ramp-set input on the second accel/decel times are used, else the first.
// - the ramp-set input turning on mid-ramp switches the rate at once.
// - the ramp-set input only selects when the source select field is 00.
// - each of the five terminals may be given the ramp-set, coast or trip function.
// - while coast stop is on the output drive is off and the motor coasts.
// - when coast stop goes off with run still active, drive resumes.
// - restart after coast is from zero or from motor speed per the restart mode.
// - restart after coast waits the programmed delay; zero means no wait.
// - each terminal has a polarity bit so coast stop can be active low.
// - a trip input rising edge latches a trip, shows the trip code, stops output.
// - the trip stays latched until a reset command, then the block is in stop.
// - alarm rises at once on a trip and drops with the reset command.
// - without start protection, run still on after reset resumes driving.
// - with start protection, a cleared trip needs a fresh run edge to restart.
// - start protection is off out of reset, so run already on at power-up is never held off.
`timescale 1ns/1ps
`default_nettype none
module dif_ctrl #(
  parameter int TICK_CYC = dif_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [dif_pkg::N_TERM-1:0] i_term,
  input wire logic i_run,
  input wire logic [dif_pkg::FW-1:0] i_motor_speed,
  input wire logic [dif_pkg::AW-1:0] i_addr,
  input wire logic [dif_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [dif_pkg::DW-1:0] o_rdata,
  output logic o_drive_en,
  output logic [dif_pkg::FW-1:0] o_freq,
  output logic o_alarm,
  output logic [7:0] o_err_code,
  output logic o_irq
);
  import dif_pkg::*;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

  dif_term_if term();

  logic [FUNC_W-1:0] func_q;
  logic [N_TERM-1:0] pol_q;
  logic [FW-1:0] acc1_q;
  logic [FW-1:0] dec1_q;
  logic [FW-1:0] acc2_q;
  logic [FW-1:0] dec2_q;
  logic [CFG_W-1:0] cfg_q;
  logic [FW-1:0] dly_q;
  logic [FW-1:0] tgt_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic [FW-1:0] ramp_cnt_q;
  logic [FW-1:0] freq_q;
  logic [FW-1:0] dly_cnt_q;
  dif_state_t state_q;
  logic run_q;
  logic pwrup_q;
  logic need_edge_q;

  logic wr_hit;
  logic reset_cmd;
  logic start_protection;
  logic run_rise;
  logic trip_ev;
  logic use_second;
  logic [FW-1:0] acc_time;
  logic [FW-1:0] dec_time;
  logic [FW-1:0] goal;
  logic accelerating;
  logic [FW-1:0] rate;
  logic dly_zero;
  logic restart_ev;
  logic coast_ev;
  logic [IRQ_W-1:0] irq_ev;

  dif_term_cond u_cond (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_term(i_term),
    .i_func(func_q),
    .i_pol(pol_q),
    .term(term.src)
  );

  assign wr_hit = i_wr;
  assign reset_cmd = wr_hit && (i_addr == ADDR_CMD) &&
                     i_wdata[CMD_RESET_BIT];
  assign start_protection = cfg_q[CFG_USP_BIT];
  assign run_rise = i_run && !run_q;
  assign trip_ev = term.trip_rise;
  assign dly_zero = (dly_cnt_q == '0);

  // ramp set selection is combinational so a change bites mid-ramp
  assign use_second = (cfg_q[CFG_SRC_LSB +: 8] == RAMP_SRC_TERMINAL) &&
                      term.ramp2;
  assign acc_time = use_second ? acc2_q : acc1_q;
  assign dec_time = use_second ? dec2_q : dec1_q;
  assign goal = (i_run && (state_q == ST_RUN)) ? tgt_q : '0;
  assign accelerating = (freq_q < goal);
  assign rate = accelerating ? acc_time : dec_time;

  assign restart_ev = (state_q == ST_WAIT) && !term.coast && i_run &&
                      dly_zero;
  assign coast_ev = (state_q == ST_RUN) && term.coast;
  assign irq_ev = {restart_ev, coast_ev, trip_ev};

  // configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      func_q <= FUNC_RST;
      pol_q <= POL_RST;
      acc1_q <= TIME1_RST;
      dec1_q <= TIME1_RST;
      acc2_q <= TIME2_RST;
      dec2_q <= TIME2_RST;
      cfg_q <= CFG_RST;
      dly_q <= DLY_RST;
      tgt_q <= TGT_RST;
      irq_mask_q <= IRQ_RST;
    end else if (wr_hit) begin
      unique case (i_addr)
        ADDR_FUNC: func_q <= i_wdata[FUNC_W-1:0];
        ADDR_POL: pol_q <= i_wdata[N_TERM-1:0];
        ADDR_ACC1: acc1_q <= i_wdata[FW-1:0];
        ADDR_DEC1: dec1_q <= i_wdata[FW-1:0];
        ADDR_ACC2: acc2_q <= i_wdata[FW-1:0];
        ADDR_DEC2: dec2_q <= i_wdata[FW-1:0];
        ADDR_CFG: cfg_q <= i_wdata[CFG_W-1:0];
        ADDR_DLY: dly_q <= i_wdata[FW-1:0];
        ADDR_TGT: tgt_q <= i_wdata[FW-1:0];
        ADDR_IRQ_MASK: irq_mask_q <= i_wdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // sticky events, set beats a same-cycle clear
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      irq_st_q <= IRQ_RST;
    end else if (wr_hit && (i_addr == ADDR_IRQ_ST)) begin
      irq_st_q <= (irq_st_q & ~i_wdata[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_st_q <= irq_st_q | irq_ev;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_st_q & irq_mask_q);
    end
  end

  // 1 ms time base for ramp and restart delay
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= TICK_LAST) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= 16'(tick_cnt_q + 16'h0001);
      tick_q <= 1'b0;
    end
  end

  // power-up marker and run edge history
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pwrup_q <= 1'b1;
      run_q <= 1'b0;
    end else begin
      pwrup_q <= 1'b0;
      run_q <= i_run;
    end
  end

  // a protected trip reset arms the need for a fresh run edge
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      need_edge_q <= 1'b0;
    end else if ((state_q == ST_TRIP) && reset_cmd && start_protection) begin
      need_edge_q <= 1'b1;
    end else if (!i_run) begin
      need_edge_q <= 1'b0;
    end
  end

  // operating state
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q <= ST_STOP;
    end else if (trip_ev) begin
      state_q <= ST_TRIP;
    end else begin
      unique case (state_q)
        ST_STOP: begin
          if (pwrup_q && start_protection && i_run) begin
            state_q <= ST_HOLD;
          end else if (i_run && !term.coast &&
                       (!need_edge_q || run_rise)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (term.coast) begin
            state_q <= ST_COAST;
          end else if (!i_run && (freq_q == '0)) begin
            state_q <= ST_STOP;
          end
        end
        ST_COAST: begin
          if (!term.coast) begin
            state_q <= i_run ? ST_WAIT : ST_STOP;
          end
        end
        ST_WAIT: begin
          if (term.coast) begin
            state_q <= ST_COAST;
          end else if (!i_run) begin
            state_q <= ST_STOP;
          end else if (dly_zero) begin
            state_q <= ST_RUN;
          end
        end
        ST_TRIP: begin
          // latched regardless of the trip input level
          if (reset_cmd) begin
            state_q <= ST_STOP;
          end
        end
        ST_HOLD: begin
          if (!i_run) begin
            state_q <= ST_STOP;
          end else if (!start_protection) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_STOP;
      endcase
    end
  end

  // restart delay, loaded as coast releases
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      dly_cnt_q <= '0;
    end else if ((state_q == ST_COAST) && !term.coast) begin
      dly_cnt_q <= dly_q;
    end else if ((state_q == ST_WAIT) && tick_q && !dly_zero) begin
      dly_cnt_q <= 16'(dly_cnt_q - 16'h0001);
    end
  end

  // output frequency ramp
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      freq_q <= '0;
      ramp_cnt_q <= '0;
    end else if (state_q != ST_RUN) begin
      ramp_cnt_q <= '0;
      if (restart_ev && cfg_q[CFG_MODE_BIT]) begin
        freq_q <= i_motor_speed;
      end else begin
        freq_q <= '0;
      end
    end else if (tick_q) begin
      if (freq_q == goal) begin
        ramp_cnt_q <= '0;
      end else if (ramp_cnt_q >= rate) begin
        // one 0.1 unit step per time setting plus one elapsed ticks
        ramp_cnt_q <= '0;
        if (accelerating) begin
          freq_q <= 16'(freq_q + 16'h0001);
        end else begin
          freq_q <= 16'(freq_q - 16'h0001);
        end
      end else begin
        ramp_cnt_q <= 16'(ramp_cnt_q + 16'h0001);
      end
    end
  end

  // drive stage, cut in the same cycle a trip or coast is seen
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_drive_en <= 1'b0;
      o_freq <= '0;
    end else begin
      o_drive_en <= (state_q == ST_RUN) && !trip_ev && !term.coast;
      // frequency is cut together with the drive so both drop as one
      o_freq <= ((state_q == ST_RUN) && !trip_ev && !term.coast) ?
                freq_q : '0;
    end
  end

  // alarm and error code
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_alarm <= 1'b0;
      o_err_code <= ERR_NONE;
    end else if (trip_ev) begin
      o_alarm <= 1'b1;
      o_err_code <= ERR_EXT_TRIP;
    end else if (reset_cmd) begin
      o_alarm <= 1'b0;
      o_err_code <= ERR_NONE;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else if (!i_rd) begin
      o_rdata <= '0;
    end else begin
      case (i_addr)
        ADDR_FUNC: o_rdata <= DW'(func_q);
        ADDR_POL: o_rdata <= DW'(pol_q);
        ADDR_ACC1: o_rdata <= DW'(acc1_q);
        ADDR_DEC1: o_rdata <= DW'(dec1_q);
        ADDR_ACC2: o_rdata <= DW'(acc2_q);
        ADDR_DEC2: o_rdata <= DW'(dec2_q);
        ADDR_CFG: o_rdata <= DW'(cfg_q);
        ADDR_DLY: o_rdata <= DW'(dly_q);
        ADDR_TGT: o_rdata <= DW'(tgt_q);
        ADDR_STAT: begin
          o_rdata <= '0;
          o_rdata[5:0] <= state_q;
          o_rdata[STAT_SEL_BIT] <= use_second;
          o_rdata[STAT_EDGE_BIT] <= need_edge_q;
          o_rdata[STAT_FREQ_LSB +: FW] <= freq_q;
        end
        ADDR_IRQ_ST: o_rdata <= DW'(irq_st_q);
        ADDR_IRQ_MASK: o_rdata <= DW'(irq_mask_q);
        ADDR_ERR: o_rdata <= DW'(o_err_code);
        default: o_rdata <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: rtl/dif_pkg.sv
package dif_pkg;
  localparam int N_TERM = 5;
  localparam int FC_W = 5;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int FW = 16;
  localparam int IRQ_W = 3;
  localparam int CFG_W = 10;
  localparam int FUNC_W = N_TERM * FC_W;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // terminal function codes
  localparam logic [FC_W-1:0] FN_RAMP2 = 5'h09;
  localparam logic [FC_W-1:0] FN_COAST = 5'h0B;
  localparam logic [FC_W-1:0] FN_TRIP = 5'h0C;

  localparam logic [7:0] RAMP_SRC_TERMINAL = 8'h00;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_EXT_TRIP = 8'h0C;

  // register offsets
  localparam logic [AW-1:0] ADDR_FUNC = 8'h00;
  localparam logic [AW-1:0] ADDR_POL = 8'h04;
  localparam logic [AW-1:0] ADDR_ACC1 = 8'h08;
  localparam logic [AW-1:0] ADDR_DEC1 = 8'h0C;
  localparam logic [AW-1:0] ADDR_ACC2 = 8'h10;
  localparam logic [AW-1:0] ADDR_DEC2 = 8'h14;
  localparam logic [AW-1:0] ADDR_CFG = 8'h18;
  localparam logic [AW-1:0] ADDR_DLY = 8'h1C;
  localparam logic [AW-1:0] ADDR_TGT = 8'h20;
  localparam logic [AW-1:0] ADDR_CMD = 8'h24;
  localparam logic [AW-1:0] ADDR_STAT = 8'h28;
  localparam logic [AW-1:0] ADDR_IRQ_ST = 8'h2C;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 8'h30;
  localparam logic [AW-1:0] ADDR_ERR = 8'h34;

  // field positions
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_MODE_BIT = 8;
  localparam int CFG_USP_BIT = 9;
  localparam int CMD_RESET_BIT = 0;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_COAST = 1;
  localparam int IRQ_RESTART = 2;
  localparam int STAT_SEL_BIT = 6;
  localparam int STAT_EDGE_BIT = 7;
  localparam int STAT_FREQ_LSB = 16;

  // reset values
  localparam logic [FUNC_W-1:0] FUNC_RST = 25'h0000000;
  localparam logic [N_TERM-1:0] POL_RST = 5'h00;
  localparam logic [FW-1:0] TIME1_RST = 16'h000A;
  localparam logic [FW-1:0] TIME2_RST = 16'h0014;
  localparam logic [FW-1:0] DLY_RST = 16'h0000;
  localparam logic [FW-1:0] TGT_RST = 16'h0000;
  localparam logic [CFG_W-1:0] CFG_RST = 10'h000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  typedef enum logic [5:0] {
    ST_STOP = 6'h01,
    ST_RUN = 6'h02,
    ST_COAST = 6'h04,
    ST_WAIT = 6'h08,
    ST_TRIP = 6'h10,
    ST_HOLD = 6'h20
  } dif_state_t;
endpackage

// file: rtl/dif_term_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dif_term_if;
  logic ramp2;
  logic coast;
  logic trip_rise;
  modport src(output ramp2, output coast, output trip_rise);
  modport dst(input ramp2, input coast, input trip_rise);
endinterface
`default_nettype wire

// file: rtl/dif_term_cond.sv
`timescale 1ns/1ps
`default_nettype none
module dif_term_cond (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [dif_pkg::N_TERM-1:0] i_term,
  input wire logic [dif_pkg::FUNC_W-1:0] i_func,
  input wire logic [dif_pkg::N_TERM-1:0] i_pol,
  dif_term_if.src term
);
  import dif_pkg::*;

  logic [N_TERM-1:0] s1_q;
  logic [N_TERM-1:0] s2_q;
  logic [N_TERM-1:0] act;
  logic trip_lvl;
  logic trip_q;

  // any terminal that is active and assigned the given function
  function automatic logic any_fn(input logic [N_TERM-1:0] a,
                                  input logic [FUNC_W-1:0] f,
                                  input logic [FC_W-1:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < N_TERM; i++) begin
      if (a[i] && (f[i*FC_W +: FC_W] == code)) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= i_term;
      s2_q <= s1_q;
    end
  end

  // polarity applied after the synchroniser, before any edge logic
  assign act = s2_q ^ i_pol;

  assign term.ramp2 = any_fn(act, i_func, FN_RAMP2);
  assign term.coast = any_fn(act, i_func, FN_COAST);
  assign trip_lvl = any_fn(act, i_func, FN_TRIP);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= trip_lvl;
    end
  end

  // one pulse per qualified off-to-on change
  assign term.trip_rise = trip_lvl & ~trip_q;
endmodule
`default_nettype wire

// file: verification/dif_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dif_ctrl_assertions #(
  parameter int TICK_CYC = dif_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [dif_pkg::N_TERM-1:0] i_term,
  input wire logic i_run,
  input wire logic [dif_pkg::AW-1:0] i_addr,
  input wire logic [dif_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [dif_pkg::DW-1:0] o_rdata,
  input wire logic o_drive_en,
  input wire logic [dif_pkg::FW-1:0] o_freq,
  input wire logic o_alarm,
  input wire logic [7:0] o_err_code
);
  import dif_pkg::*;
  logic [N_TERM-1:0] term_prev_q;
  logic [3:0] quiet_q;
  logic rst_cmd;
  assign rst_cmd = i_wr && (i_addr == ADDR_CMD) && i_wdata[CMD_RESET_BIT];
  // cycles since the raw terminals last moved, saturating
  always_ff @(posedge i_clk) begin
    term_prev_q <= i_term;
    if (!i_nrst) begin
      quiet_q <= 4'hF;
    end else if (i_term != term_prev_q) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  AST_ERR_FOLLOWS_ALARM: assert property (
    o_err_code == (o_alarm ? ERR_EXT_TRIP : ERR_NONE))
    else $error("error code does not follow alarm");
  AST_TRIP_STOPS_DRIVE: assert property (o_alarm |-> !o_drive_en)
    else $error("drive on during trip");
  AST_FREQ_ZERO_OFF: assert property (!o_drive_en |-> o_freq == '0)
    else $error("frequency with drive off");
  AST_TRIP_HOLDS: assert property (
    o_alarm && !rst_cmd && !$past(rst_cmd) |=> o_alarm)
    else $error("alarm dropped without reset");
  AST_RESET_CLEARS: assert property (
    o_alarm && rst_cmd && quiet_q > 4'h6 |-> ##[1:2] !o_alarm)
    else $error("reset command left alarm on");
  AST_ALARM_NEEDS_EDGE: assert property (
    $rose(o_alarm) |-> quiet_q <= 4'h6)
    else $error("alarm without terminal edge");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read slot");
  AST_DRIVE_NEEDS_RUN: assert property (
    $rose(o_drive_en) |-> $past(i_run) || $past(i_run, 2) || $past(i_run, 3))
    else $error("drive started without run");
  AST_POWER_UP_QUIET: assert property (
    $rose(i_nrst) |-> !o_drive_en && !o_alarm && o_freq == '0)
    else $error("outputs active after reset");
  AST_RAMP_ONE_STEP: assert property (
    o_drive_en && $past(o_drive_en) && $past(o_drive_en, 2) |->
    o_freq == $past(o_freq) || o_freq == $past(o_freq) + 16'h1 ||
    o_freq == $past(o_freq) - 16'h1)
    else $error("frequency jumped while driving");
  COV_TRIP: cover property ($rose(o_alarm));
  COV_COAST: cover property ($fell(o_drive_en) && !o_alarm);
  COV_RESTART: cover property ($rose(o_drive_en) && o_freq != '0);
endmodule
bind dif_ctrl dif_ctrl_assertions #(.TICK_CYC(TICK_CYC)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_term(i_term), .i_run(i_run),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_drive_en(o_drive_en), .o_freq(o_freq),
  .o_alarm(o_alarm), .o_err_code(o_err_code));
`default_nettype wire

// file: verification/dif_contact_model.sv
`timescale 1ns/1ps
`default_nettype none
module dif_contact_model (
  input wire logic i_clk,
  input wire logic [dif_pkg::N_TERM-1:0] i_want_term,
  input wire logic i_want_run,
  output logic [dif_pkg::N_TERM-1:0] o_term,
  output logic o_run
);
  import dif_pkg::*;
  initial begin
    o_term = '0;
    o_run = 1'b0;
  end
  // contacts move only just after an edge, never mid-cycle
  always @(posedge i_clk) begin
    o_term <= i_want_term;
    o_run <= i_want_run; // a run off-on pulse restarts a protected drive
  end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dif_pkg::*;
  localparam int TICK = 4;
  logic clk, nrst, run, want_run, wr, rd, drive, alarm, irq;
  logic [N_TERM-1:0] term, want_term;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, rv;
  logic [FW-1:0] freq;
  logic [7:0] err;
  int err_count, checks_done;
  dif_contact_model u_model (.i_clk(clk), .i_want_term(want_term),
    .i_want_run(want_run), .o_term(term), .o_run(run));
  dif_ctrl #(.TICK_CYC(TICK)) u_dut (.i_clk(clk), .i_nrst(nrst),
    .i_term(term), .i_run(run), .i_motor_speed(16'h0040), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_drive_en(drive), .o_freq(freq), .o_alarm(alarm),
    .o_err_code(err), .o_irq(irq));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp,
    input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic set_in(input logic [N_TERM-1:0] t, input logic r);
    @(posedge clk);
    want_term <= t;
    want_run <= r;
  endtask
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  function automatic logic probe(input int sel, input logic [FW-1:0] k);
    case (sel)
      0: probe = freq >= k;
      1: probe = freq <= k;
      2: probe = drive;
      3: probe = !drive;
      default: probe = alarm;
    endcase
  endfunction
  // bounded wait; running out is a failure and ends the run
  task automatic wait_for(input int sel, input logic [FW-1:0] k,
    input int bound, output int cnt);
    cnt = 0;
    #1;
    while (probe(sel, k) !== 1'b1) begin
      if (cnt >= bound) begin
        chk(1'b0, 1'b1, "wait ran out");
        give_verdict();
      end
      cyc(1);
      cnt++;
    end
  endtask
  task automatic t_regs();
    rd_reg(ADDR_ACC1, rv);
    chk(rv, {16'h0, TIME1_RST}, "accel 1 reset");
    rd_reg(ADDR_DEC2, rv);
    chk(rv, {16'h0, TIME2_RST}, "decel 2 reset");
    wr_reg(ADDR_ERR, 32'h000000FF);
    rd_reg(ADDR_ERR, rv);
    chk(rv, 32'h0, "error code read only");
    rd_reg(8'h3C, rv);
    chk(rv, 32'h0, "unmapped read");
    wr_reg(ADDR_FUNC, {17'h0, FN_TRIP, FN_COAST, FN_RAMP2});
    rd_reg(ADDR_FUNC, rv);
    chk(rv, {17'h0, FN_TRIP, FN_COAST, FN_RAMP2}, "function map");
  endtask
  task automatic t_ramp();
    int t0, t1;
    wr_reg(ADDR_ACC1, 32'h1);
    wr_reg(ADDR_ACC2, 32'h0);
    wr_reg(ADDR_DEC2, 32'h0);
    wr_reg(ADDR_TGT, 32'h100);
    set_in(5'h00, 1'b1);
    wait_for(0, 16'h4, 200, t0);
    wait_for(0, 16'h8, 200, t1);
    chk(t1, 4 * 2 * TICK, "first set accel");
    set_in(5'h01, 1'b1);
    wait_for(0, 16'hC, 200, t0);
    wait_for(0, 16'h10, 200, t1);
    chk(t1, 4 * TICK, "second set mid ramp");
    rd_reg(ADDR_STAT, rv);
    chk(rv[STAT_SEL_BIT], 1'b1, "second set in use");
    wr_reg(ADDR_CFG, 32'h1);
    wait_for(0, freq + 16'h1, 200, t0);
    wait_for(0, freq + 16'h4, 200, t1);
    chk(t1, 4 * 2 * TICK, "terminal ignored off source");
    wr_reg(ADDR_CFG, 32'h0);
    set_in(5'h01, 1'b0);
    wait_for(1, 16'hC, 400, t0);
    wait_for(1, 16'h8, 200, t1);
    chk(t1, 4 * TICK, "second set decel");
    wait_for(1, 16'h0, 200, t0);
    rd_reg(ADDR_STAT, rv);
    chk(rv[5:0], ST_STOP, "stopped");
  endtask
  task automatic t_coast();
    int t0;
    wr_reg(ADDR_CFG, 32'h100);
    wr_reg(ADDR_DLY, 32'h3);
    set_in(5'h01, 1'b1);
    wait_for(0, 16'h10, 200, t0);
    set_in(5'h03, 1'b1);
    wait_for(3, 16'h0, 8, t0);
    cyc(4);
    chk({drive, freq}, 17'h0, "coasting");
    set_in(5'h01, 1'b1);
    wait_for(2, 16'h0, 40, t0);
    chk(t0 >= 8 && t0 <= 20, 1'b1, "restart delay");
    chk(freq >= 16'h40 && freq <= 16'h41, 1'b1, "from speed");
    wr_reg(ADDR_CFG, 32'h0);
    wr_reg(ADDR_DLY, 32'h0);
    set_in(5'h03, 1'b1);
    wait_for(3, 16'h0, 8, t0);
    set_in(5'h01, 1'b1);
    wait_for(2, 16'h0, 8, t0);
    chk(freq <= 16'h1, 1'b1, "from zero");
    wr_reg(ADDR_POL, 32'h2);
    wait_for(3, 16'h0, 8, t0);
    set_in(5'h03, 1'b1);
    wait_for(2, 16'h0, 12, t0);
  endtask
  task automatic t_trip();
    int t0;
    wr_reg(ADDR_IRQ_MASK, 32'h1);
    set_in(5'h07, 1'b1);
    wait_for(4, 16'h0, 8, t0);
    chk(err, ERR_EXT_TRIP, "trip code");
    set_in(5'h03, 1'b1);
    cyc(10);
    chk({alarm, drive, irq}, 3'b101, "trip latched");
    wr_reg(ADDR_CMD, 32'h1);
    cyc(2);
    chk({alarm, err}, 9'h000, "reset clears");
    wait_for(2, 16'h0, 12, t0);
    wr_reg(ADDR_IRQ_ST, 32'h1);
    cyc(2);
    chk(irq, 1'b0, "irq cleared");
    wr_reg(ADDR_CFG, 32'h200);
    set_in(5'h07, 1'b1);
    wait_for(4, 16'h0, 8, t0);
    set_in(5'h03, 1'b1);
    wr_reg(ADDR_CMD, 32'h1);
    cyc(20);
    chk({alarm, drive}, 2'b00, "protected no restart");
    rd_reg(ADDR_STAT, rv);
    chk(rv[STAT_EDGE_BIT], 1'b1, "fresh run needed");
    set_in(5'h03, 1'b0);
    set_in(5'h03, 1'b1);
    wait_for(2, 16'h0, 12, t0);
  endtask
  initial begin
    err_count = 0;
    checks_done = 0;
    nrst = 1'b0;
    want_term = '0;
    want_run = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_ramp();
    t_coast();
    t_trip();
    give_verdict();
  end
endmodule
`default_nettype wire
